// ### rtl/qps_irq_summary.sv
// Shared status change interrupt and summary registers behind the management port
`timescale 1ns/1ps
`include "qps_params.svh"

// Clock domains
//   Sys side: flags, enables, previous samples, the pin and the snapshot publisher.
//   Management side: frame slave, snapshot copy, write and clear requests.
// Crossings
//   Snapshot: the sys side loads a word and flips a toggle; the management side
//   copies it once the toggle has passed two flops, then echoes the toggle back.
//   The sys side reloads only after that echo returns, so the word never moves
//   while it is being copied.
//   Enable write and flag clear: the management side parks its payload and
//   flips a toggle on the same edge; the sys side acts on the toggle edge after
//   two flops, by which time the payload has long settled.
// Limitations
//   Read data is a snapshot and may lag the live state by a few sys cycles.
//   Two reads close together may both report a flag the first one cleared.
//   The management clock may stop between frames; the snapshot then waits.
//   The clock enable freezes only the sys side. Frames still complete, and
//   their write and clear requests are taken up once the enable returns.
//   Management reset is the block reset through two management flops, so the
//   management clock must give a few edges while reset is held.
//   The address decode answers only for the chosen base on address bits 4:2.

module qps_irq_summary
    import qps_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       reset_in,
    input  wire logic       ce_in,
    input  wire logic [3:0] link_up_in,
    input  wire logic [3:0] full_duplex_in,
    input  wire logic [3:0] an_alert_in,
    input  wire logic [3:0] jabber_in,
    input  wire logic [3:0] pol_reversed_in,
    input  wire logic [3:0] rate_fault_in,
    input  wire logic       irq_func_en_in,
    input  wire logic       mgmt_clk_in,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_out,
    output logic            status_change_irq_n_out
);

    // Rising edge of a per-port level against its previous sample
    function automatic logic [3:0] qps_rise(input logic [3:0] now, input logic [3:0] old);
        qps_rise = now & ~old;
    endfunction : qps_rise

    // ---------------- System clock domain ----------------
    logic [4:0]            flag_ff;
    logic [4:0]            nxt_flag;
    logic [4:0]            en_ff;
    logic [3:0]            rm_ff;
    logic [3:0]            nxt_rm;
    logic [3:0]            link_q_ff;
    logic [3:0]            dup_q_ff;
    logic [3:0]            an_q_ff;
    logic [3:0]            err_q_ff;
    logic                  primed_ff;
    logic                  irq_n_ff;
    logic [`QPS_SNAP_W-1:0] pub_ff;
    logic                  pub_tgl_ff;
    logic                  s_wr_s1_ff;
    logic                  s_wr_s2_ff;
    logic                  s_wr_s3_ff;
    logic                  s_clr_s1_ff;
    logic                  s_clr_s2_ff;
    logic                  s_clr_s3_ff;
    logic                  s_ack_s1_ff;
    logic                  s_ack_s2_ff;

    // ---------------- Management clock domain ----------------
    qps_mgmt_state_type    m_state_ff;
    logic [5:0]            m_cnt_ff;
    logic [11:0]           m_hdr_ff;
    logic [15:0]           m_sh_ff;
    logic                  mdio_out_ff;
    logic                  mdio_oe_ff;
    logic [4:0]            m_wr_ff;
    logic                  m_wr_tgl_ff;
    logic [8:0]            m_clr_ff;
    logic                  m_clr_tgl_ff;
    logic [`QPS_SNAP_W-1:0] m_snap_ff;
    logic                  m_seen_ff;
    logic                  m_pub_s1_ff;
    logic                  m_pub_s2_ff;
    logic                  m_rst_s1_ff;
    logic                  m_rst_s2_ff;

    // Event sources
    //   Link and duplex report any transition.
    //   Negotiation alert and jabber report rising edges only.
    //   A rate mismatch reports when its sticky bit goes from clear to set,
    //   whatever the jabber bit of that port is doing at the time.
    //   Nothing is reported on the first enabled cycle after reset, since the
    //   previous-value registers still hold reset zeros there.
    // Event decode, gated until the previous-value registers hold real samples
    wire [3:0]  err_now  = jabber_in | rm_ff;
    wire        ev_link  = |(link_up_in ^ link_q_ff);
    wire        ev_dup   = |(full_duplex_in ^ dup_q_ff);
    wire        ev_an    = |qps_rise(an_alert_in, an_q_ff);
    wire        ev_err   = |qps_rise(jabber_in, err_q_ff)
                         | |(rate_fault_in & ~rm_ff);
    wire [4:1]  ev       = {ev_link, ev_dup, ev_an, ev_err} & {4{primed_ff}};
    wire        wr_ev    = s_wr_s2_ff ^ s_wr_s3_ff;
    wire        clr_ev   = s_clr_s2_ff ^ s_clr_s3_ff;
    wire [4:0]  clr_flag = clr_ev ? m_clr_ff[4:0] : 5'h00;
    wire [3:0]  clr_rm   = clr_ev ? m_clr_ff[8:5] : 4'h0;
    wire        pub_load = (s_ack_s2_ff == pub_tgl_ff);

    // Sticky flags: a set in the clearing cycle wins over the clear
    assign nxt_flag[4:1] = (flag_ff[4:1] & ~clr_flag[4:1]) | ev;
    assign nxt_flag[0]   = (flag_ff[0] & ~clr_flag[0]) | (|ev);
    assign nxt_rm        = (rm_ff & ~clr_rm) | rate_fault_in;

    // Register images built from live state
    wire [15:0] irq_word = {3'h0, en_ff, 3'h0, flag_ff};
    wire [15:0] sum_word;
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp = gp + 1) begin : g_sum
            assign sum_word[4*gp+`QPS_S_LINK] = link_up_in[gp];
            assign sum_word[4*gp+`QPS_S_DUP]  = full_duplex_in[gp];
            assign sum_word[4*gp+`QPS_S_AN]   = an_alert_in[gp];
            assign sum_word[4*gp+`QPS_S_ERR]  = err_now[gp];
        end
    endgenerate

    // Enabled flag with global enable and irq_func_en_in drives the pin low
    wire irq_act = irq_func_en_in & en_ff[`QPS_F_GLOB]
                 & (|(flag_ff[4:1] & en_ff[4:1]));

    // Flags, per-port errors and previous samples
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            flag_ff   <= `QPS_FLAG_RST;
            rm_ff     <= 4'h0;
            link_q_ff <= 4'h0;
            dup_q_ff  <= 4'h0;
            an_q_ff   <= 4'h0;
            err_q_ff  <= 4'h0;
            primed_ff <= 1'b0;
        end else if (ce_in) begin
            flag_ff   <= nxt_flag;
            rm_ff     <= nxt_rm;
            link_q_ff <= link_up_in;
            dup_q_ff  <= full_duplex_in;
            an_q_ff   <= an_alert_in;
            err_q_ff  <= jabber_in;
            primed_ff <= 1'b1;
        end
    end

    // Enable bits written from the management side, and the pin
    // The pin is registered so it cannot glitch while flags and enables settle
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            en_ff    <= `QPS_EN_RST;
            irq_n_ff <= 1'b1;
        end else if (ce_in) begin
            if (wr_ev) begin
                en_ff <= m_wr_ff;
            end
            irq_n_ff <= ~irq_act;
        end
    end

    // Publish a register snapshot whenever the previous one was taken
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pub_ff     <= {`QPS_SNAP_W{1'b0}};
            pub_tgl_ff <= 1'b0;
        end else if (ce_in && pub_load) begin
            pub_ff     <= {rm_ff, pol_reversed_in, jabber_in, sum_word, irq_word};
            pub_tgl_ff <= ~pub_tgl_ff;
        end
    end

    // Each toggle passes two flops; the third flop of the write and clear toggles only
    // serves edge detection, so nothing reads the first flop but the second.
    // Synchronisers for toggles arriving from the management domain
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            s_wr_s1_ff  <= 1'b0;
            s_wr_s2_ff  <= 1'b0;
            s_wr_s3_ff  <= 1'b0;
            s_clr_s1_ff <= 1'b0;
            s_clr_s2_ff <= 1'b0;
            s_clr_s3_ff <= 1'b0;
            s_ack_s1_ff <= 1'b0;
            s_ack_s2_ff <= 1'b0;
        end else if (ce_in) begin
            s_wr_s1_ff  <= m_wr_tgl_ff;
            s_wr_s2_ff  <= s_wr_s1_ff;
            s_wr_s3_ff  <= s_wr_s2_ff;
            s_clr_s1_ff <= m_clr_tgl_ff;
            s_clr_s2_ff <= s_clr_s1_ff;
            s_clr_s3_ff <= s_clr_s2_ff;
            s_ack_s1_ff <= m_seen_ff;
            s_ack_s2_ff <= s_ack_s1_ff;
        end
    end

    assign status_change_irq_n_out = irq_n_ff;

    // ---------------- Management side ----------------
    // Frame layout on the data line, one bit per rising management edge:
    //   32 or more ones, a zero, a one, two opcode bits, five address bits,
    //   five register bits, two turnaround bits, sixteen data bits MSB first.
    // The header is decoded on the edge that samples the last register bit;
    // the read word and the clear request come from the snapshot there.
    // Frames for other addresses, registers or opcodes are let go at once and
    // the slave goes back to hunting for a preamble.
    wire [12:0] hdr_w    = {m_hdr_ff, mdio_in};
    wire [1:0]  hdr_op   = hdr_w[11:10];
    wire        addr_hit = hdr_w[12] & (hdr_w[9:7] == `QPS_PHY_BASE);
    wire [1:0]  port_sel = hdr_w[6:5];
    wire [4:0]  reg_sel  = hdr_w[4:0];
    wire [3:0]  snap_rm  = m_snap_ff[`QPS_SNAP_RM_LSB +: 4];
    wire [3:0]  snap_pol = m_snap_ff[`QPS_SNAP_POL_LSB +: 4];
    wire [3:0]  snap_jab = m_snap_ff[`QPS_SNAP_JAB_LSB +: 4];
    wire [3:0]  port_hot = 4'h1 << port_sel;
    wire        is_irq   = (reg_sel == `QPS_REG_IRQ);
    wire        is_sum   = (reg_sel == `QPS_REG_SUM);
    wire        is_perr  = (reg_sel == `QPS_REG_PERR);
    wire        rd_ok    = addr_hit & (hdr_op == `QPS_OP_RD) & (is_irq | is_sum | is_perr);
    wire        wr_ok    = addr_hit & (hdr_op == `QPS_OP_WR) & is_irq;
    wire [15:0] perr_w   = {13'h0000, snap_rm[port_sel], snap_pol[port_sel], snap_jab[port_sel]};
    wire [15:0] rd_word  = is_irq ? m_snap_ff[15:0] :
                           is_sum ? m_snap_ff[`QPS_SNAP_SUM_LSB +: 16] : perr_w;
    // Clear exactly what this read reports, so later events stay pending
    wire [8:0]  rd_clr   = is_irq  ? {4'h0, m_snap_ff[4:0]} :
                           is_perr ? {snap_rm & port_hot, 5'h00} : 9'h000;

    // Reset and snapshot toggle brought into the management domain
    always_ff @(posedge mgmt_clk_in) begin
        m_rst_s1_ff <= reset_in;
        m_rst_s2_ff <= m_rst_s1_ff;
        m_pub_s1_ff <= pub_tgl_ff;
        m_pub_s2_ff <= m_pub_s1_ff;
    end

    // Take a fresh snapshot; the held seen bit is also the acknowledge
    always_ff @(posedge mgmt_clk_in) begin
        if (m_rst_s2_ff) begin
            m_snap_ff <= {`QPS_SNAP_W{1'b0}};
            m_seen_ff <= 1'b0;
        end else if (m_pub_s2_ff != m_seen_ff) begin
            m_snap_ff <= pub_ff;
            m_seen_ff <= m_pub_s2_ff;
        end
    end

    // Read timing: the turnaround edge drives a zero, the next sixteen edges put
    // out one bit each, and the edge after bit 0 lets go of the line.
    // Write timing: two turnaround edges are skipped, sixteen bits shift in, and
    // bits 12:8 are parked together with the last one.
    // Management frame slave: preamble, header, turnaround, data
    always_ff @(posedge mgmt_clk_in) begin
        if (m_rst_s2_ff) begin
            m_state_ff   <= QPS_PRE;
            m_cnt_ff     <= 6'h00;
            m_hdr_ff     <= 12'h000;
            m_sh_ff      <= 16'h0000;
            mdio_out_ff  <= 1'b0;
            mdio_oe_ff   <= 1'b0;
            m_wr_ff      <= `QPS_EN_RST;
            m_wr_tgl_ff  <= 1'b0;
            m_clr_ff     <= 9'h000;
            m_clr_tgl_ff <= 1'b0;
        end else begin
            case (m_state_ff)
                QPS_PRE: begin
                    if (mdio_in) begin
                        if (m_cnt_ff != `QPS_PRE_LEN) begin
                            m_cnt_ff <= m_cnt_ff + 6'h01;
                        end
                    end else begin
                        if (m_cnt_ff == `QPS_PRE_LEN) begin
                            m_state_ff <= QPS_HDR;
                        end
                        m_cnt_ff <= 6'h00;
                    end
                end
                QPS_HDR: begin
                    m_hdr_ff <= hdr_w[11:0];
                    m_cnt_ff <= m_cnt_ff + 6'h01;
                    if (m_cnt_ff == `QPS_HDR_LAST) begin
                        m_cnt_ff <= 6'h00;
                        if (rd_ok) begin
                            m_state_ff   <= QPS_TA_RD;
                            m_sh_ff      <= rd_word;
                            m_clr_ff     <= rd_clr;
                            m_clr_tgl_ff <= ~m_clr_tgl_ff;
                        end else if (wr_ok) begin
                            m_state_ff <= QPS_TA_WR;
                        end else begin
                            m_state_ff <= QPS_PRE;
                        end
                    end
                end
                QPS_TA_RD: begin
                    mdio_oe_ff  <= 1'b1;
                    mdio_out_ff <= 1'b0;
                    m_state_ff  <= QPS_RD;
                end
                QPS_RD: begin
                    if (m_cnt_ff == `QPS_DATA_BITS) begin
                        mdio_oe_ff  <= 1'b0;
                        mdio_out_ff <= 1'b0;
                        m_cnt_ff    <= 6'h00;
                        m_state_ff  <= QPS_PRE;
                    end else begin
                        mdio_out_ff <= m_sh_ff[15];
                        m_sh_ff     <= {m_sh_ff[14:0], 1'b0};
                        m_cnt_ff    <= m_cnt_ff + 6'h01;
                    end
                end
                QPS_TA_WR: begin
                    m_cnt_ff <= m_cnt_ff + 6'h01;
                    if (m_cnt_ff == 6'h01) begin
                        m_cnt_ff   <= 6'h00;
                        m_state_ff <= QPS_WR;
                    end
                end
                QPS_WR: begin
                    m_sh_ff  <= {m_sh_ff[14:0], mdio_in};
                    m_cnt_ff <= m_cnt_ff + 6'h01;
                    if (m_cnt_ff == `QPS_DATA_LAST) begin
                        m_wr_ff     <= m_sh_ff[`QPS_EN_MSB-1:`QPS_EN_LSB-1];
                        m_wr_tgl_ff <= ~m_wr_tgl_ff;
                        m_cnt_ff    <= 6'h00;
                        m_state_ff  <= QPS_PRE;
                    end
                end
                default: begin
                    m_state_ff <= QPS_PRE;
                    m_cnt_ff   <= 6'h00;
                    mdio_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign mdio_out    = mdio_out_ff;
    assign mdio_oe_out = mdio_oe_ff;

endmodule : qps_irq_summary

// ### rtl/qps_params.svh
// Constants for the quad port status interrupt summary block
`ifndef QPS_PARAMS_SVH
`define QPS_PARAMS_SVH

// Register addresses seen on the management frame
`define QPS_REG_IRQ      5'h10
`define QPS_REG_SUM      5'h11
`define QPS_REG_PERR     5'h13
// Upper three bits of the port addresses (value arbitrary)
`define QPS_PHY_BASE     3'h0
// Management frame fields
`define QPS_PRE_LEN      6'h20
`define QPS_OP_RD        2'h2
`define QPS_OP_WR        2'h1
`define QPS_HDR_LAST     6'h0C
`define QPS_DATA_LAST    6'h0F
`define QPS_DATA_BITS    6'h10
// Reset values
`define QPS_IRQ_RST      16'h0000
`define QPS_SUM_RST      16'h0000
`define QPS_FLAG_RST     5'h00
`define QPS_EN_RST       5'h00
// Flag and enable index inside the five bit groups
`define QPS_F_GLOB       0
`define QPS_F_ERR        1
`define QPS_F_AN         2
`define QPS_F_DUP        3
`define QPS_F_LINK       4
// Enable field position in the interrupt register
`define QPS_EN_LSB       8
`define QPS_EN_MSB       12
// Bit order inside each summary nibble
`define QPS_S_ERR        0
`define QPS_S_AN         1
`define QPS_S_DUP        2
`define QPS_S_LINK       3
// Snapshot layout handed to the management clock domain
`define QPS_SNAP_W       44
`define QPS_SNAP_SUM_LSB 16
`define QPS_SNAP_JAB_LSB 32
`define QPS_SNAP_POL_LSB 36
`define QPS_SNAP_RM_LSB  40

`endif

// ### rtl/qps_pkg.sv
// Types for the quad port status interrupt summary block
package qps_pkg;

    typedef enum logic [2:0] {
        QPS_PRE,
        QPS_HDR,
        QPS_TA_RD,
        QPS_RD,
        QPS_TA_WR,
        QPS_WR
    } qps_mgmt_state_type;

endpackage : qps_pkg

// ### test/qps_irq_summary_asserts.sv
// Pin level checks for the status interrupt summary block
`timescale 1ns/1ps

module qps_irq_summary_asserts (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic irq_func_en_in,
    input wire logic mgmt_clk_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_out,
    input wire logic status_change_irq_n_out
);
    logic [7:0] gap_ff;

    // Management clocks since the block last let go of the data line
    always_ff @(posedge mgmt_clk_in) begin
        if (reset_in || mdio_oe_out) gap_ff <= 8'h00;
        else if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
    end

    irq_after_rst_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $fell(reset_in) |-> status_change_irq_n_out [*2])
        else $error("Interrupt pin active just after reset");
    func_off_quiet_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !irq_func_en_in [*2] |=> status_change_irq_n_out)
        else $error("Interrupt pin active while its function is off");
    irq_fall_en_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $fell(status_change_irq_n_out) |-> $past(irq_func_en_in))
        else $error("Interrupt pin fell without its function enabled");
    read_window_a: assert property (@(posedge mgmt_clk_in) disable iff (reset_in)
        $rose(mdio_oe_out) |-> mdio_oe_out [*8] ##1 mdio_oe_out [*8] ##1 mdio_oe_out
            ##1 !mdio_oe_out)
        else $error("Read drive window is not seventeen clocks");
    turn_zero_a: assert property (@(posedge mgmt_clk_in) disable iff (reset_in)
        $rose(mdio_oe_out) |-> !mdio_out)
        else $error("Turnaround bit not driven low");
    read_end_a: assert property (@(posedge mgmt_clk_in) disable iff (reset_in)
        $fell(mdio_oe_out) |-> $past(mdio_oe_out, 17) && !$past(mdio_oe_out, 18))
        else $error("Read drive ended at the wrong clock");
    header_gap_a: assert property (@(posedge mgmt_clk_in) disable iff (reset_in)
        $rose(mdio_oe_out) |-> gap_ff >= 8'h2E)
        else $error("Data line driven before a full header");
    mgmt_rst_a: assert property (@(posedge mgmt_clk_in) disable iff (reset_in)
        $fell(reset_in) |-> !mdio_oe_out [*3])
        else $error("Data line driven just after reset");
endmodule : qps_irq_summary_asserts

bind qps_irq_summary qps_irq_summary_asserts i_chk (
    .sys_clk_in              (sys_clk_in),
    .reset_in                (reset_in),
    .irq_func_en_in          (irq_func_en_in),
    .mgmt_clk_in             (mgmt_clk_in),
    .mdio_out                (mdio_out),
    .mdio_oe_out             (mdio_oe_out),
    .status_change_irq_n_out (status_change_irq_n_out)
);

// ### test/qps_mgmt_master.sv
// Management controller model that clocks frames onto the data line
`timescale 1ns/1ps
`include "qps_params.svh"

module qps_mgmt_master (
    output logic      mgmt_clk_out,
    output logic      mdio_drv_out,
    output logic      mdio_oe_out,
    input  wire logic mdio_wire_in
);
    // Clock stands low and the line is released between frames
    initial begin
        mgmt_clk_out = 1'b0;
        mdio_drv_out = 1'b1;
        mdio_oe_out  = 1'b0;
    end

    // One period: line set while low, sampled just before the rise
    task automatic tick(input logic d, input logic oe, output logic smp);
        mdio_drv_out = d;
        mdio_oe_out  = oe;
        #6;
        smp = mdio_wire_in;
        mgmt_clk_out = 1'b1;
        #6;
        mgmt_clk_out = 1'b0;
    endtask : tick

    // Released clocks, read as ones through the pull-up
    task automatic idle(input int n);
        logic s;
        repeat (n) tick(1'b1, 1'b0, s);
    endtask : idle

    // Preamble and header, then read back or write sixteen bits MSB first
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] adr,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hFFFFFFFF, 2'b01, op, phy, adr};
        rd  = 16'h0000;
        for (int i = 45; i >= 0; i--) tick(hdr[i], 1'b1, s);
        for (int i = 0; i < 18; i++) begin
            tick((i < 2) ? (i == 0) : wd[17 - i], op != `QPS_OP_RD, s);
            if (i >= 2) rd = {rd[14:0], s};
        end
    endtask : frame
endmodule : qps_mgmt_master

// ### test/qps_irq_summary_tb_top.sv
// Self-checking bench for the status interrupt summary block
`timescale 1ns/1ps
`include "qps_params.svh"

module qps_irq_summary_tb_top;
    logic        sys_clk_in;
    logic        reset_in;
    logic        irq_func_en;
    logic [3:0]  link_up, full_dup, an_alert, jabber, pol_rev, rate_fault;
    logic [3:0]  nl, nd, na, nj;
    logic [4:0]  en, flg;
    logic [15:0] v;
    logic [1:0]  p;
    logic        fen, rp, ce;
    wire  logic  mgmt_clk, mst_d, mst_e, dut_d, dut_e, irq_n, mdio_wire;
    int          seed = 32'hC2B3;
    int          error_cnt = 0;
    int          checks_done = 0;

    // Data line with pull-up, driven by whichever side enables
    assign mdio_wire = dut_e ? dut_d : (mst_e ? mst_d : 1'b1);

    qps_irq_summary i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ce_in(ce),
        .link_up_in(link_up), .full_duplex_in(full_dup), .an_alert_in(an_alert),
        .jabber_in(jabber), .pol_reversed_in(pol_rev), .rate_fault_in(rate_fault),
        .irq_func_en_in(irq_func_en), .mgmt_clk_in(mgmt_clk), .mdio_in(mdio_wire),
        .mdio_out(dut_d), .mdio_oe_out(dut_e), .status_change_irq_n_out(irq_n));
    qps_mgmt_master i_mst (.mgmt_clk_out(mgmt_clk), .mdio_drv_out(mst_d),
        .mdio_oe_out(mst_e), .mdio_wire_in(mdio_wire));

    // System clock, 20 ns
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [15:0] sum_exp(input logic [3:0] rm);
        logic [15:0] s;
        for (int n = 0; n < 4; n++) s[4*n +: 4] = {link_up[n], full_dup[n], an_alert[n],
            jabber[n] | rm[n]};
        return s;
    endfunction : sum_exp

    function automatic logic irq_exp(input logic [4:0] e, input logic [4:0] f, input logic g);
        return !(g && e[0] && |(e[4:1] & f[4:1]));
    endfunction : irq_exp

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: interrupt pin %b, expected %b", $time, got, exp);
        end
    endtask : cmp_pin

    task automatic rd(input logic [1:0] prt, input logic [4:0] adr, output logic [15:0] d);
        i_mst.frame(`QPS_OP_RD, {`QPS_PHY_BASE, prt}, adr, 16'h0000, d);
        i_mst.idle(64);
    endtask : rd

    task automatic wr(input logic [4:0] adr, input logic [15:0] d);
        logic [15:0] x;
        i_mst.frame(`QPS_OP_WR, {`QPS_PHY_BASE, 2'h0}, adr, d, x);
        i_mst.idle(64);
    endtask : wr

    task automatic end_of_test;
        $display("Checks done %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Watchdog against a hung frame
    initial begin
        #300000;
        error_cnt++;
        end_of_test;
    end

    // Main sequence
    initial begin
        reset_in    = 1'b1;
        irq_func_en = 1'b1;
        ce          = 1'b1;
        {link_up, full_dup, an_alert, jabber, pol_rev, rate_fault} = 24'h000000;
        fork
            i_mst.idle(8);
            repeat (16) @(negedge sys_clk_in);
        join
        reset_in = 1'b0;
        i_mst.idle(4);
        repeat (10) @(negedge sys_clk_in);
        // Reset values; refused addresses leave the line at its pull-up
        rd(2'h0, `QPS_REG_IRQ, v);
        cmp_word(v, `QPS_IRQ_RST);
        rd(2'h0, 5'h12, v);
        cmp_word(v, 16'hFFFF);
        i_mst.frame(`QPS_OP_RD, 5'h04, `QPS_REG_IRQ, 16'h0000, v);
        i_mst.idle(64);
        cmp_word(v, 16'hFFFF);
        // Writable bits only, shared by all ports; summary ignores writes
        wr(`QPS_REG_IRQ, 16'hFFFF);
        wr(`QPS_REG_SUM, 16'hFFFF);
        for (int k = 0; k < 4; k++) begin
            rd(k[1:0], `QPS_REG_IRQ, v);
            cmp_word(v, 16'h1F00);
        end
        rd(2'h3, `QPS_REG_SUM, v);
        cmp_word(v, `QPS_SUM_RST);
        cmp_pin(irq_n, 1'b1);
        // Random events; pass 0 global off, pass 1 function off, pass 2 sys side frozen
        for (int i = 0; i < 8; i++) begin
            en = (i == 0) ? 5'h1E : (i == 2) ? 5'h1F : 5'($random(seed));
            wr(`QPS_REG_IRQ, {3'h0, en, 8'h00});
            @(negedge sys_clk_in);
            nl = (i < 3) ? ~link_up : 4'($random(seed));
            nd = 4'($random(seed));
            na = 4'($random(seed));
            nj = 4'($random(seed));
            p = 2'($random(seed));
            rp = 1'($random(seed));
            fen = (i != 1);
            flg[4] = |(nl ^ link_up);
            flg[3] = |(nd ^ full_dup);
            flg[2] = |(na & ~an_alert);
            flg[1] = |(nj & ~jabber) | rp;
            flg[0] = |flg[4:1];
            irq_func_en = fen;
            ce = (i != 2);
            {link_up, full_dup, an_alert, jabber} = {nl, nd, na, nj};
            pol_rev = 4'($random(seed));
            rate_fault = 4'(rp) << p;
            @(negedge sys_clk_in);
            // Frozen pass: pending events must not reach the pin until enable returns
            if (!ce) begin
                repeat (4) @(negedge sys_clk_in);
                cmp_pin(irq_n, 1'b1);
                ce = 1'b1;
                @(negedge sys_clk_in);
            end
            rate_fault = 4'h0;
            repeat (10) @(negedge sys_clk_in);
            cmp_pin(irq_n, irq_exp(en, flg, fen));
            rd(p, `QPS_REG_SUM, v);
            cmp_word(v, sum_exp(4'(rp) << p));
            rd(p, `QPS_REG_IRQ, v);
            cmp_word(v, {3'h0, en, 3'h0, flg});
            rd(p, `QPS_REG_IRQ, v);
            cmp_word(v, {3'h0, en, 8'h00});
            cmp_pin(irq_n, 1'b1);
            rd(p, `QPS_REG_PERR, v);
            cmp_word(v, {13'h0000, rp, pol_rev[p], jabber[p]});
            rd(p, `QPS_REG_PERR, v);
            cmp_word(v, {13'h0000, 1'b0, pol_rev[p], jabber[p]});
        end
        end_of_test;
    end
endmodule : qps_irq_summary_tb_top
